// file: src/isa_ext_regs.vh
`ifndef ISA_EXT_REGS_VH
`define ISA_EXT_REGS_VH
// Opcode patterns; single-word ones have register number in bits 2:0 masked off, push/load words match exactly
`define OPC_BIT_REVERSE   16'h00c0
`define OPC_BYTE_SWAP     16'h02c0
`define OPC_FIND_FIRST    16'h04c0
`define OPC_SINGLE_MASK   16'hfff8
`define OPC_PUSH_LOAD_HI  16'h40e7
`define OPC_PUSH_LOAD_LO  16'h46fc
// Field positions
`define SR_SUPER_BIT      13
`define CCR_X_BIT         4
`define CCR_N_BIT         3
`define CCR_Z_BIT         2
`define CCR_V_BIT         1
`define CCR_C_BIT         0
// Values
`define STACK_STEP        32'h00000004
`define FIND_ALL_ZERO     6'h20
`define RESET_WORD32      32'h00000000
`define RESET_WORD16      16'h0000
`endif

// file: src/bit_ops_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "isa_ext_regs.vh"
module bit_ops_unit #(
  parameter WIDTH = 32
) (
  // Operand
  input  wire [WIDTH-1:0] operand,
  // Results
  output wire [WIDTH-1:0] bit_reversed,
  output wire [WIDTH-1:0] byte_swapped,
  output wire [WIDTH-1:0] first_set_count
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_rev
      assign bit_reversed[i] = operand[WIDTH-1-i];
    end
    for (i = 0; i < WIDTH/8; i = i + 1) begin : g_swap
      assign byte_swapped[8*i +: 8] = operand[WIDTH-8-8*i +: 8];
    end
  endgenerate

  // Priority scan from the top bit; the loop runs low to high so the highest set bit wins
  function [5:0] lead_count;
    input [31:0] v;
    integer k;
    begin
      lead_count = `FIND_ALL_ZERO;
      for (k = 0; k < 32; k = k + 1) begin
        if (v[k]) begin
          lead_count = 6'd31 - k[5:0];
        end
      end
    end
  endfunction

  assign first_set_count = {{(WIDTH-6){1'b0}}, lead_count(operand[31:0])};
endmodule // bit_ops_unit
`default_nettype wire

// file: src/isa_ext_exec.v
// Summary of operation
// - Bit reverse mirrors register, flags untouched
// - Byte swap reverses byte order, flags untouched
// - Find-first scans from bit 31 downward
// - Result is distance of first one
// - All-zero operand yields 32
// - Supervisor: push status, load immediate; else trap
// - Immediate with bit 13 clear traps
// - Decode two-word push/load opcode plus immediate
// - Flags after push/load equal immediate bits
`timescale 1ns/1ns
`default_nettype none
`include "isa_ext_regs.vh"
module isa_ext_exec (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Issue from decoder
  input  wire        issue_valid,
  input  wire [15:0] instr_word0,
  input  wire [15:0] instr_word1,
  input  wire [15:0] ext_word,
  // Architectural state in
  input  wire [31:0] operand_data,
  input  wire [15:0] status_word_in,
  input  wire [31:0] stack_pointer_in,
  // Completion
  output reg         done_q,
  output reg         unknown_op_q,
  output reg         priv_trap_q,
  // Register file write
  output reg         reg_wr_en_q,
  output reg  [2:0]  reg_wr_idx_q,
  output reg  [31:0] reg_wr_data_q,
  // Condition code write
  output reg         ccr_wr_en_q,
  output reg  [4:0]  ccr_wr_data_q,
  // Status word and stack pointer write
  output reg         sr_wr_en_q,
  output reg  [15:0] sr_wr_data_q,
  output reg         sp_wr_en_q,
  output reg  [31:0] sp_wr_data_q,
  // Stack store
  output reg         store_en_q,
  output reg  [31:0] store_addr_q,
  output reg  [31:0] store_data_q
);
  wire [31:0] bit_reversed;
  wire [31:0] byte_swapped;
  wire [31:0] first_set_count;

  bit_ops_unit #(
    .WIDTH(32)
  ) u_bit_ops (
    .operand         (operand_data),
    .bit_reversed    (bit_reversed),
    .byte_swapped    (byte_swapped),
    .first_set_count (first_set_count)
  );

  function match_single;
    input [15:0] word;
    input [15:0] pattern;
    begin
      match_single = ((word & `OPC_SINGLE_MASK) == pattern);
    end
  endfunction

  wire is_rev  = match_single(instr_word0, `OPC_BIT_REVERSE);
  wire is_swap = match_single(instr_word0, `OPC_BYTE_SWAP);
  wire is_find = match_single(instr_word0, `OPC_FIND_FIRST);
  wire is_push = (instr_word0 == `OPC_PUSH_LOAD_HI) && (instr_word1 == `OPC_PUSH_LOAD_LO);

  wire        supervisor = status_word_in[`SR_SUPER_BIT];
  // Trap takes priority and leaves all state untouched, so the handler sees the original frame
  wire        push_trap  = !supervisor || !ext_word[`SR_SUPER_BIT];
  wire [31:0] new_sp     = stack_pointer_in - `STACK_STEP;
  wire [4:0]  find_flags = {status_word_in[`CCR_X_BIT], operand_data[31], (operand_data == 32'h00000000),
                            1'b0, 1'b0};

  // Operation class codes; binary keeps the decode register narrow
  localparam [2:0] CLASS_IDLE    = 3'h0;
  localparam [2:0] CLASS_REVERSE = 3'h1;
  localparam [2:0] CLASS_SWAP    = 3'h2;
  localparam [2:0] CLASS_FIND    = 3'h3;
  localparam [2:0] CLASS_PUSH    = 3'h4;
  localparam [2:0] CLASS_UNKNOWN = 3'h5;

  reg [2:0]  op_class;
  reg        done_d;
  reg        unknown_d;
  reg        trap_d;
  reg        reg_wr_d;
  reg [31:0] reg_data_d;
  reg        ccr_wr_d;
  reg        push_ok_d;

  // Priority follows the order of the tests below
  always @* begin
    op_class = CLASS_IDLE;
    if (issue_valid) begin
      if (is_rev) begin
        op_class = CLASS_REVERSE;
      end else if (is_swap) begin
        op_class = CLASS_SWAP;
      end else if (is_find) begin
        op_class = CLASS_FIND;
      end else if (is_push) begin
        op_class = CLASS_PUSH;
      end else begin
        op_class = CLASS_UNKNOWN;
      end
    end
  end

  always @* begin
    done_d     = 1'b0;
    unknown_d  = 1'b0;
    trap_d     = 1'b0;
    reg_wr_d   = 1'b0;
    reg_data_d = operand_data;
    ccr_wr_d   = 1'b0;
    push_ok_d  = 1'b0;
    case (op_class)
      CLASS_REVERSE: begin
        done_d     = 1'b1;
        reg_wr_d   = 1'b1;
        reg_data_d = bit_reversed;
      end
      CLASS_SWAP: begin
        done_d     = 1'b1;
        reg_wr_d   = 1'b1;
        reg_data_d = byte_swapped;
      end
      CLASS_FIND: begin
        done_d     = 1'b1;
        reg_wr_d   = 1'b1;
        reg_data_d = first_set_count;
        ccr_wr_d   = 1'b1;
      end
      CLASS_PUSH: begin
        done_d    = 1'b1;
        trap_d    = push_trap;
        push_ok_d = !push_trap;
      end
      CLASS_UNKNOWN: begin
        // Unrecognised words only report back; no state is touched
        done_d    = 1'b1;
        unknown_d = 1'b1;
      end
      default: begin
        done_d    = 1'b0;
      end
    endcase
  end

  // Completion pulses
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_q       <= 1'b0;
      unknown_op_q <= 1'b0;
      priv_trap_q  <= 1'b0;
    end else begin
      done_q       <= done_d;
      unknown_op_q <= unknown_d;
      priv_trap_q  <= trap_d;
    end
  end

  // Register file write; data loads every cycle and only counts with the enable
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_wr_en_q   <= 1'b0;
      reg_wr_idx_q  <= 3'h0;
      reg_wr_data_q <= `RESET_WORD32;
    end else begin
      reg_wr_en_q   <= reg_wr_d;
      reg_wr_idx_q  <= instr_word0[2:0];
      reg_wr_data_q <= reg_data_d;
    end
  end

  // Condition codes, written by find-first only
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ccr_wr_en_q   <= 1'b0;
      ccr_wr_data_q <= 5'h00;
    end else begin
      ccr_wr_en_q   <= ccr_wr_d;
      ccr_wr_data_q <= find_flags;
    end
  end

  // Status word and stack pointer load
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sr_wr_en_q   <= 1'b0;
      sr_wr_data_q <= `RESET_WORD16;
      sp_wr_en_q   <= 1'b0;
      sp_wr_data_q <= `RESET_WORD32;
    end else begin
      sr_wr_en_q   <= push_ok_d;
      sr_wr_data_q <= ext_word;
      sp_wr_en_q   <= push_ok_d;
      sp_wr_data_q <= new_sp;
    end
  end

  // Stack store; no hazard logic, so the caller must feed back the new stack pointer
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      store_en_q   <= 1'b0;
      store_addr_q <= `RESET_WORD32;
      store_data_q <= `RESET_WORD32;
    end else begin
      store_en_q   <= push_ok_d;
      store_addr_q <= new_sp;
      store_data_q <= {16'h0000, status_word_in};
    end
  end
endmodule // isa_ext_exec
`default_nettype wire

// file: tb/isa_ext_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module isa_ext_monitor (
  input wire logic clock, rstn, issue_valid, priv_trap_q, reg_wr_en_q, sr_wr_en_q,
  input wire logic [15:0] instr_word0, instr_word1, ext_word, status_word_in, sr_wr_data_q,
  input wire logic [31:0] operand_data, stack_pointer_in, reg_wr_data_q, sp_wr_data_q, store_data_q,
  input wire logic [4:0] ccr_wr_data_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire ff = issue_valid && instr_word0[15:3] == 13'h98;
  wire pl = issue_valid && instr_word0 == 16'h40e7 && instr_word1 == 16'h46fc && status_word_in[13];
  bit_mirror_a: assert property (issue_valid && instr_word0[15:3] == 13'h18 |=>
    reg_wr_en_q && reg_wr_data_q == {<<{$past(operand_data)}}) else $error("mirror wrong");
  byte_order_a: assert property (issue_valid && instr_word0[15:3] == 13'h58 |=>
    reg_wr_data_q == {<<8{$past(operand_data)}}) else $error("byte order wrong");
  scan_top_a: assert property (ff && operand_data[31] |=> reg_wr_data_q == 32'h0) else $error("ff top");
  scan_zero_a: assert property (ff && operand_data == 32'h0 |=> reg_wr_data_q == 32'h20) else $error("ff 32");
  scan_flags_a: assert property (ff |=> ccr_wr_data_q[1:0] == 2'h0) else $error("ff flags");
  push_word_a: assert property (pl && ext_word[13] |=> sp_wr_data_q == $past(stack_pointer_in) - 32'h4
    && store_data_q == {16'h0, $past(status_word_in)}) else $error("push");
  user_trap_a: assert property (pl && !ext_word[13] |=> priv_trap_q && !sr_wr_en_q) else $error("trap");
  sr_load_a: assert property (pl && ext_word[13] |=> sr_wr_en_q && sr_wr_data_q == $past(ext_word))
    else $error("load");
endmodule // isa_ext_monitor
bind isa_ext_exec isa_ext_monitor mon (.*);
`default_nettype wire

// file: tb/core_side.sv
`timescale 1ns/1ns
`default_nettype none
module core_side #(parameter SR_INIT = 16'h2700, SP_INIT = 32'h1000) (
  input wire logic clock, rstn, user, sr_wr_en_q, sp_wr_en_q,
  input wire logic [15:0] sr_wr_data_q,
  input wire logic [31:0] sp_wr_data_q,
  output logic [15:0] status_word_in,
  output logic [31:0] stack_pointer_in
);
  logic [15:0] sr_q;
  // User forces bit 13 low so a trap can be reached without a legal load
  assign status_word_in = {sr_q[15:14], sr_q[13] & !user, sr_q[12:0]};
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sr_q <= SR_INIT;
      stack_pointer_in <= SP_INIT;
    end else begin
      if (sr_wr_en_q) sr_q <= sr_wr_data_q;
      if (sp_wr_en_q) stack_pointer_in <= sp_wr_data_q;
    end
  end
endmodule // core_side
`default_nettype wire

// file: tb/isa_ext_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module isa_ext_exec_tb;
  logic clock = 0, rstn = 0, issue_valid = 0, user = 0;
  logic [15:0] instr_word0 = 0, instr_word1 = 0, ext_word = 0, status_word_in, sr_wr_data_q;
  logic [31:0] operand_data = 0, stack_pointer_in, reg_wr_data_q, sp_wr_data_q, store_addr_q, store_data_q;
  logic done_q, unknown_op_q, priv_trap_q, reg_wr_en_q, ccr_wr_en_q, sr_wr_en_q, sp_wr_en_q, store_en_q;
  logic [2:0] reg_wr_idx_q;
  logic [4:0] ccr_wr_data_q;
  int failures = 0, checks_done = 0, cyc = 0, i;
  logic [31:0] d[4] = '{32'h8000_0000, 32'h1, 32'h0, 32'h0001_0000};
  logic [31:0] n[4] = '{32'h0, 32'h1f, 32'h20, 32'hf};
  always #25 clock = ~clock;
  isa_ext_exec uut (.*);
  core_side #(.SR_INIT(16'h2700), .SP_INIT(32'h1000)) far (.*);
  task end_sim;
    $display("Errors %0d in %0d checks", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [39:0] g, e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // One issue, then look at the single-cycle answer
  task op(input logic [15:0] w0, w1, e, input logic [31:0] v);
    @(posedge clock) #1;
    {instr_word0, instr_word1, ext_word, operand_data, issue_valid} = {w0, w1, e, v, 1'b1};
    @(posedge clock) #1 issue_valid = 0;
    chk(done_q, 1);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 400) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    #1 rstn = 1;
    op(16'h00c5, 0, 0, 32'h1);
    chk({ccr_wr_en_q, reg_wr_idx_q, reg_wr_data_q}, {4'h5, 32'h8000_0000});
    op(16'h02c2, 0, 0, 32'h1122_3344);
    chk({ccr_wr_en_q, reg_wr_data_q}, 32'h4433_2211);
    op(16'h40e7, 16'h46fc, 16'h271f, 0);
    chk({sp_wr_en_q, store_en_q}, 2'b11);
    chk(sp_wr_data_q, 32'h0000_0ffc);
    chk(store_addr_q, 32'h0000_0ffc);
    chk(store_data_q, 32'h2700);
    chk({sr_wr_en_q, sr_wr_data_q}, 17'h1_271f);
    op(16'h40e7, 16'h46fc, 16'h0705, 0);
    chk({priv_trap_q, sr_wr_en_q, store_en_q}, 3'b100);
    user = 1;
    op(16'h40e7, 16'h46fc, 16'h2700, 0);
    chk({priv_trap_q, sp_wr_en_q}, 2'b10);
    user = 0;
    op(16'h40e7, 16'h46fd, 16'h2700, 0);
    chk({unknown_op_q, sr_wr_en_q}, 2'b10);
    op(16'h00c8, 0, 0, 0);
    chk({unknown_op_q, reg_wr_en_q}, 2'b10);
    for (i = 0; i < 4; i++) begin
      op(16'h04c7, 0, 0, d[i]);
      chk(reg_wr_data_q, n[i]);
      chk({reg_wr_en_q, ccr_wr_en_q, reg_wr_idx_q}, 5'h1f);
      chk(ccr_wr_data_q, {1'b1, d[i][31], d[i] == 0, 2'b0});
    end
    end_sim();
  end
endmodule // isa_ext_exec_tb
`default_nettype wire
